// >>> design/pmcg_clock_gate.sv
// Summary of operation
// - system and peripheral clocks are the master clock divided by two
// - run mode keeps core, memory and peripheral clocks running
// - wait mode gates core and memory clocks, peripherals keep running
// - unmasked peripheral interrupt in wait mode restores core clocks
// - stop mode keeps divider running but gates most outgoing clocks
// - stop exits only on can traffic, unclocked irq, watchdog, external or power-on reset
// - can wake-up loses the first message; later messages are received
// - per-clock enables switch single clocks off regardless of mode
// - oscillator and pll may be shut down when unused
`include "pmcg_defines.svh"

module pmcg_clock_gate #(
  parameter int PCE_WIDTH = `PMCG_PCE_WIDTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  wait_req,
  input  wire logic                  stop_req,
  input  wire logic                  periph_irq,
  input  wire logic                  can_traffic,
  input  wire logic                  unclocked_irq,
  input  wire logic [PCE_WIDTH-1:0]  peripheral_clock_enable_reg,
  input  wire logic                  clock_disable_control,
  input  wire logic                  debug_port_clock_enable,
  input  wire logic                  osc_in_use,
  input  wire logic                  pll_in_use,
  output logic                       core_clk_en,
  output logic                       mem_clk_en,
  output logic [PCE_WIDTH-1:0]       periph_clk_en,
  output logic                       debug_clk_en,
  output logic                       sys_clk_phase,
  output logic                       can_drop_first,
  output logic                       osc_shutdown,
  output logic                       pll_shutdown,
  output pmcg_pkg::pmcg_mode_e       mode
);
  import pmcg_pkg::*;

  // wider enable words could not be loaded from the shared reset constant
  if (PCE_WIDTH < 1 || PCE_WIDTH > `PMCG_PCE_WIDTH) begin : g_width_check
    $error("pmcg_clock_gate: PCE_WIDTH out of range");
  end

  // stop wins when both instructions are flagged in one cycle
  function automatic pmcg_mode_e pmcg_request(
    input logic stop_in,
    input logic wait_in
  );
    pmcg_mode_e target;
    target = PMCG_RUN;
    if (stop_in) begin
      target = PMCG_STOP;
    end else if (wait_in) begin
      target = PMCG_WAIT;
    end
    return target;
  endfunction : pmcg_request

  function automatic logic pmcg_core_allowed(
    input pmcg_mode_e m
  );
    logic allowed;
    allowed = 1'b0;
    case (m)
      PMCG_RUN: begin
        allowed = 1'b1;
      end
      PMCG_WAIT: begin
        allowed = 1'b0;
      end
      PMCG_STOP: begin
        allowed = 1'b0;
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
    return allowed;
  endfunction : pmcg_core_allowed

  function automatic logic pmcg_periph_allowed(
    input pmcg_mode_e m
  );
    logic allowed;
    allowed = 1'b0;
    case (m)
      PMCG_RUN: begin
        allowed = 1'b1;
      end
      PMCG_WAIT: begin
        allowed = 1'b1;
      end
      PMCG_STOP: begin
        allowed = 1'b0;
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
    return allowed;
  endfunction : pmcg_periph_allowed

  // resets leave stop through reset_n itself, so only the other wakes show here
  function automatic logic pmcg_wake(
    input pmcg_mode_e m,
    input logic       irq_in,
    input logic       can_in,
    input logic       nclk_in
  );
    logic wake;
    wake = 1'b0;
    case (m)
      PMCG_WAIT: begin
        wake = irq_in || nclk_in;
      end
      PMCG_STOP: begin
        wake = can_in || nclk_in;
      end
      default: begin
        wake = 1'b0;
      end
    endcase
    return wake;
  endfunction : pmcg_wake

  typedef struct packed {
    logic                 div;
    pmcg_mode_e           mode;
    logic                 core_en;
    logic                 mem_en;
    logic [PCE_WIDTH-1:0] per_en;
    logic                 dbg_en;
    logic                 can_drop;
    logic                 osc_off;
    logic                 pll_off;
  } pmcg_state_s;

  pmcg_state_s state_reg;
  pmcg_state_s state_next;

  logic                 core_want;
  logic                 per_want;
  logic                 wake_now;
  logic [PCE_WIDTH-1:0] per_want_vec;

  assign core_want = pmcg_core_allowed(state_reg.mode);
  assign per_want  = pmcg_periph_allowed(state_reg.mode);
  assign wake_now  = pmcg_wake(state_reg.mode, periph_irq, can_traffic, unclocked_irq);

  // each peripheral gate follows its own enable bit while the mode allows it
  for (genvar gi = 0; gi < PCE_WIDTH; gi++) begin : g_per_gate
    assign per_want_vec[gi] = per_want && peripheral_clock_enable_reg[gi];
  end

  always_comb begin
    state_next     = state_reg;
    state_next.div = ~state_reg.div;
    case (state_reg.mode)
      PMCG_RUN: begin
        state_next.mode = pmcg_request(stop_req, wait_req);
      end
      PMCG_WAIT: begin
        if (wake_now) begin
          state_next.mode = PMCG_RUN;
        end
      end
      PMCG_STOP: begin
        if (wake_now) begin
          state_next.mode = PMCG_RUN;
          if (can_traffic) begin
            state_next.can_drop = 1'b1;
          end
        end
      end
      default: begin
        state_next.mode = PMCG_RUN;
      end
    endcase
    // the first message ends when traffic goes quiet; later ones are kept
    if (state_reg.can_drop && !can_traffic && state_reg.mode == PMCG_RUN) begin
      state_next.can_drop = 1'b0;
    end
    // enables move only when the divided clock is about to go low
    if (state_reg.div) begin
      state_next.core_en = core_want && !clock_disable_control;
      state_next.mem_en  = core_want;
      state_next.per_en  = per_want_vec;
      state_next.dbg_en  = core_want && debug_port_clock_enable;
    end
    state_next.osc_off = !osc_in_use;
    state_next.pll_off = !pll_in_use;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg.div      <= 1'b0;
      state_reg.mode     <= PMCG_RUN;
      state_reg.core_en  <= 1'b1;
      state_reg.mem_en   <= 1'b1;
      state_reg.per_en   <= PCE_WIDTH'(`PMCG_PCE_RESET);
      state_reg.dbg_en   <= 1'b0;
      state_reg.can_drop <= 1'b0;
      state_reg.osc_off  <= 1'b0;
      state_reg.pll_off  <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign core_clk_en    = state_reg.core_en;
  assign mem_clk_en     = state_reg.mem_en;
  assign periph_clk_en  = state_reg.per_en;
  assign debug_clk_en   = state_reg.dbg_en;
  assign sys_clk_phase  = state_reg.div;
  assign can_drop_first = state_reg.can_drop;
  assign osc_shutdown   = state_reg.osc_off;
  assign pll_shutdown   = state_reg.pll_off;
  assign mode           = state_reg.mode;
endmodule : pmcg_clock_gate

// >>> inc/pmcg_defines.svh
`ifndef PMCG_DEFINES_SVH
`define PMCG_DEFINES_SVH

`define PMCG_MCLK_MAX_MHZ      120
`define PMCG_SYSCLK_MAX_MHZ    60
`define PMCG_PCE_WIDTH         16
`define PMCG_PCE_RESET         16'hFFFF

`endif

// >>> inc/pmcg_pkg.sv
package pmcg_pkg;
  typedef enum logic [1:0] {
    PMCG_RUN,
    PMCG_WAIT,
    PMCG_STOP
  } pmcg_mode_e;
endpackage : pmcg_pkg

// >>> verification/pmcg_clock_gate_sva.sv
module pmcg_clock_gate_sva #(
  parameter int PCE_WIDTH = 16
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 stop_req,
  input wire logic                 periph_irq,
  input wire logic                 can_traffic,
  input wire logic                 unclocked_irq,
  input wire logic                 osc_in_use,
  input wire logic                 core_clk_en,
  input wire logic                 mem_clk_en,
  input wire logic                 debug_clk_en,
  input wire logic                 sys_clk_phase,
  input wire logic                 can_drop_first,
  input wire logic                 osc_shutdown,
  input wire logic [PCE_WIDTH-1:0] periph_clk_en,
  input wire pmcg_pkg::pmcg_mode_e mode
);
  import pmcg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_div; 1 |=> sys_clk_phase != $past(sys_clk_phase); endproperty
  a_div: assert property (p_div) else $error("phase stuck");
  property p_run; (mode == PMCG_RUN)[*3] ##0 sys_clk_phase |=> mem_clk_en; endproperty
  a_run: assert property (p_run) else $error("memory clock off in run");
  property p_wait; (mode == PMCG_WAIT)[*3] ##0 sys_clk_phase |=> !core_clk_en && !mem_clk_en;
  endproperty
  a_wait: assert property (p_wait) else $error("core clock on in wait");
  property p_stop; (mode == PMCG_STOP)[*3] ##0 sys_clk_phase |=> periph_clk_en == '0;
  endproperty
  a_stop: assert property (p_stop) else $error("clock on in stop");
  // gates move only after a high phase, so no runt pulse reaches a consumer
  property p_frz; !sys_clk_phase |=> $stable(core_clk_en) && $stable(periph_clk_en); endproperty
  a_frz: assert property (p_frz) else $error("gate moved in low phase");
  property p_hold; mode == PMCG_STOP && !can_traffic && !unclocked_irq |=> mode == PMCG_STOP;
  endproperty
  a_hold: assert property (p_hold) else $error("stop left without wake");
  property p_can; mode == PMCG_STOP && can_traffic |=> mode == PMCG_RUN && can_drop_first;
  endproperty
  a_can: assert property (p_can) else $error("can wake wrong");
  property p_osc; 1 |=> osc_shutdown == !$past(osc_in_use); endproperty
  a_osc: assert property (p_osc) else $error("osc shutdown wrong");
  c_wake: cover property (mode == PMCG_WAIT && periph_irq);
  c_can: cover property (mode == PMCG_STOP && can_traffic);
  c_stop: cover property (mode == PMCG_RUN && stop_req);
endmodule : pmcg_clock_gate_sva
bind pmcg_clock_gate pmcg_clock_gate_sva #(.PCE_WIDTH(PCE_WIDTH)) i_sva (.*);

// >>> verification/pmcg_core_model.sv
module pmcg_core_model (
  input  wire logic       clk,
  input  wire logic [1:0] insn,
  output logic            wait_req,
  output logic            stop_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // each low-power instruction shows as a one-cycle request
  always_ff @(posedge clk) wait_req <= (insn == 2'h1);
  always_ff @(posedge clk) stop_req <= (insn == 2'h2);
endmodule : pmcg_core_model

// >>> verification/test_pmcg_clock_gate.sv
module test_pmcg_clock_gate;
  timeunit 1ns;
  timeprecision 1ns;
  import pmcg_pkg::*;
  logic clk = 1'h0, reset_n = 1'h0, periph_irq = 1'h0, can_traffic = 1'h0, unclocked_irq = 1'h0;
  logic clock_disable_control = 1'h0, debug_port_clock_enable = 1'h1, osc_in_use = 1'h1;
  logic pll_in_use = 1'h1, wait_req, stop_req, core_clk_en, mem_clk_en, debug_clk_en;
  logic sys_clk_phase, can_drop_first, osc_shutdown, pll_shutdown;
  logic [1:0] insn = 2'h0;
  logic [15:0] peripheral_clock_enable_reg = 16'hFFFF, periph_clk_en;
  pmcg_mode_e mode;
  int mismatches = 0, compares = 0, cycles = 0;
  pmcg_clock_gate i_dut (.*);
  pmcg_core_model i_core (.*);
  always #20 clk = ~clk;
  task step(input int n); repeat (n) @(posedge clk); #1; endtask : step
  task chk(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      report_and_stop();
    end
  end
  task t_enables;
    {clock_disable_control, osc_in_use, pll_in_use} = 3'h4;
    peripheral_clock_enable_reg = 16'h00A5;
    step(3);
    chk("periph", 16'h00A5, periph_clk_en);
    chk("core", 1'h0, core_clk_en);
    chk("osc", 1'h1, osc_shutdown);
    chk("pll", 1'h1, pll_shutdown);
    chk("mem", 1'h1, mem_clk_en);
    chk("debug", 1'h1, debug_clk_en);
    chk("phase", 1'h1, sys_clk_phase);
    {clock_disable_control, osc_in_use, pll_in_use} = 3'h3;
    peripheral_clock_enable_reg = 16'hFFFF;
    step(3);
    chk("phase", 1'h0, sys_clk_phase);
    $display("enables test done");
  endtask : t_enables
  task t_mode(input logic [1:0] op, input pmcg_mode_e m, input logic [15:0] pe);
    insn = op;
    step(1);
    insn = 2'h0;
    step(4);
    chk("mode", m, mode);
    chk("core", 1'h0, core_clk_en);
    chk("mem", 1'h0, mem_clk_en);
    chk("debug", 1'h0, debug_clk_en);
    chk("periph", pe, periph_clk_en);
    periph_irq = 1'h1;
    step(1);
    periph_irq = 1'h0;
    can_traffic = (m == PMCG_STOP);
    chk("irq wake", (m == PMCG_STOP) ? PMCG_STOP : PMCG_RUN, mode);
    step(1);
    can_traffic = 1'h0;
    chk("can wake", PMCG_RUN, mode);
    chk("drop", (m == PMCG_STOP), can_drop_first);
    step(2);
    chk("core", 1'h1, core_clk_en);
    chk("mem", 1'h1, mem_clk_en);
    chk("drop", 1'h0, can_drop_first);
    $display("mode test done");
  endtask : t_mode
  task t_unclocked;
    insn = 2'h2;
    step(1);
    insn = 2'h0;
    step(4);
    chk("mode", PMCG_STOP, mode);
    chk("mem", 1'h0, mem_clk_en);
    unclocked_irq = 1'h1;
    step(1);
    unclocked_irq = 1'h0;
    chk("nclk wake", PMCG_RUN, mode);
    chk("drop", 1'h0, can_drop_first);
    step(2);
    chk("mem", 1'h1, mem_clk_en);
    $display("unclocked test done");
  endtask : t_unclocked
  initial begin
    step(5);
    reset_n = 1'h1;
    chk("mode", PMCG_RUN, mode);
    t_enables();
    t_mode(2'h1, PMCG_WAIT, 16'hFFFF);
    t_mode(2'h2, PMCG_STOP, 16'h0000);
    t_unclocked();
    report_and_stop();
  end
endmodule : test_pmcg_clock_gate
